// ==== rtl/tcd_cmd_decoder.sv ====
/*
 * Serial command decoder of a resistive touch screen converter: takes
 * the 8-bit control word on the shift clock, holds the configuration,
 * drives plate switches, pen interrupt, busy and the result shifter.
 * Assumes the analog converter supplies adc_result on core_clk and
 * keeps it stable; the host keeps the serial timing of the link.
 */
`timescale 1ns/1ps

// How it works
// - Command bits are taken on each shift clock rise, eight per command.
// - Bits six to four pick converter input and plate driver switches.
// - Bit three low gives twelve result bits, high gives eight.
// - Single-ended codes pick inputs against ground, reference full scale.
// - Differential uses plates as reference; three codes void, 110 sleeps.
// - The last command's configuration stays until a new one replaces it.
// - Sleep starts at rise eight, acts with select high, ends on command.
// - Asleep with select high: plates open; interrupt floats or drives high.
// - Entering sleep also applies the command's two power bits.
// - After reset the device is awake, not sleeping.
// - Reference power bit updates at the seventh shift clock rise.
// - Converter power bit updates at the eighth shift clock rise.
// - Converter bit holds switches to fifth rise; select high grounds Y neg.
// - Both power bits zero: converter only converting, Y neg grounded idle.
// - Bits zero-one: converter on with select low, axis plates stay on.
// - Bits one-zero: reference always on; interrupt off fall five to twenty.
// - Both bits one: all powered, interrupt forced high with select high.
// - Decoding starts at the first high bit after select falls.
// - Busy from fall eight to nine; result MSB first from fall nine.
// - Differential keeps plate switches on from fall five to fall twenty.
module tcd_cmd_decoder
    import tcd_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire logic               shift_clock,
    input  wire logic               chip_select_n,
    input  wire logic               serial_din,
    input  wire logic               pen_touch_n,
    input  wire logic [RES_W-1:0]   adc_result,
    output logic                    serial_dout,
    output logic                    serial_dout_oe_n,
    output logic                    busy,
    output logic                    busy_oe_n,
    output logic                    touch_irq_n,
    output logic                    touch_irq_oe_n,
    output tcd_cmd_s                active_cmd,
    output logic                    ref_power_on,
    output logic                    adc_power_on,
    output logic                    sleep_active,
    output tcd_plate_s              plate_sw
);

    // ------------------------------------------------------------------
    // Link side state, cleared whenever chip select is high
    // ------------------------------------------------------------------
    logic               started_l;
    logic [4:0]         rise_cnt_l;
    logic [CMD_W-1:0]   cmd_sh_l;
    logic [2:0]         chan_l;
    logic               ref_l;
    logic               ref_done_l;
    logic               cmd_done_l;
    logic               past_l;
    logic               win_l;
    logic               conv_l;
    logic               busy_l;
    logic               dout_l;
    logic [RES_W-1:0]   out_sh_l;

    // ------------------------------------------------------------------
    // Core side state
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0]  sync_in;
    logic [SYNC_W-1:0]  sync_q;
    tcd_link_s          lnk_s;
    logic               cs_s;
    logic               pen_s;
    logic               done_d_r;
    logic               ref_d_r;
    tcd_cmd_s           cfg_r;
    logic               ref_r;
    tcd_mode_e          mode_r;
    tcd_mode_e          mode_nxt;
    logic [RES_W-1:0]   adc_hold_r;
    tcd_plate_s         plate_r;
    tcd_plate_s         plate_nxt;
    logic               irq_r;
    logic               irq_nxt;
    logic               irq_oe_n_r;
    logic               irq_oe_n_nxt;
    logic               adc_pwr_r;
    logic               adc_pwr_nxt;

    // ------------------------------------------------------------------
    // Link side decode
    // ------------------------------------------------------------------
    // Number of the rise being taken now, and of the fall that follows
    // the last rise taken.
    wire logic [4:0]    rise_now  = rise_cnt_l + 5'h01;
    wire logic [4:0]    fall_no   = rise_cnt_l;
    wire logic          cnt_sat   = (rise_cnt_l == EDGE_SAT);
    wire logic          in_word   = (rise_cnt_l < EDGE_CMD);
    wire tcd_cmd_s      word_l    = tcd_cmd_s'(cmd_sh_l);
    wire logic          is_chan   = (rise_now == EDGE_CHAN);
    wire logic          is_track  = (rise_now == EDGE_TRACK);
    wire logic          is_ref    = (rise_now == EDGE_REF);
    wire logic          is_cmd    = (rise_now == EDGE_CMD);

    // Differential keeps its window to fall twenty unless the code is void
    wire logic          win_keep  = !word_l.input_config_select &&
                                    !is_na_diff(word_l.channel_select);

    // Eight-bit results keep the top bits and trail zeros
    wire logic [RES_W-1:0] load_word = word_l.res_8bit ?
                                       {adc_hold_r[RES_W-1:4], 4'h0} :
                                       adc_hold_r;

    // ------------------------------------------------------------------
    // Start hunt and bit counter on the rise of the shift clock
    // ------------------------------------------------------------------
    // Chip select high is the frame's own end, so it clears the link
    // logic without needing any edge of a clock that may have stopped.
    always_ff @(posedge shift_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            started_l  <= 1'b0;
            rise_cnt_l <= 5'h00;
        end else if (!started_l) begin
            started_l  <= serial_din;
            rise_cnt_l <= serial_din ? 5'h01 : 5'h00;
        end else if (!cnt_sat) begin
            rise_cnt_l <= rise_now;
        end
    end

    // ------------------------------------------------------------------
    // Command shifter, one bit per rise, frozen after the eighth
    // ------------------------------------------------------------------
    always_ff @(posedge shift_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            cmd_sh_l <= 8'h00;
        end else if (!started_l) begin
            cmd_sh_l <= {7'h00, serial_din};
        end else if (in_word) begin
            cmd_sh_l <= {cmd_sh_l[CMD_W-2:0], serial_din};
        end
    end

    // ------------------------------------------------------------------
    // Words and markers for the core, each stable until the frame ends
    // ------------------------------------------------------------------
    always_ff @(posedge shift_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            chan_l     <= 3'h0;
            ref_l      <= 1'b0;
            ref_done_l <= 1'b0;
            cmd_done_l <= 1'b0;
            past_l     <= 1'b0;
        end else if (started_l) begin
            if (is_chan) begin
                chan_l <= {cmd_sh_l[1:0], serial_din};
            end
            if (is_ref) begin
                ref_l      <= serial_din;
                ref_done_l <= 1'b1;
            end
            if (is_cmd) begin
                cmd_done_l <= 1'b1;
            end
            if (is_track) begin
                past_l <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Windows, busy and result shifter on the fall of the shift clock
    // ------------------------------------------------------------------
    // adc_hold_r is frozen by the core while select is low, so reading
    // it here at fall eight is a stable word, not a racing one.
    always_ff @(negedge shift_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            win_l    <= 1'b0;
            conv_l   <= 1'b0;
            busy_l   <= 1'b0;
            dout_l   <= 1'b0;
            out_sh_l <= '0;
        end else begin
            if (fall_no == EDGE_TRACK) begin
                win_l  <= 1'b1;
                conv_l <= 1'b1;
            end else if (fall_no == EDGE_CMD) begin
                win_l    <= win_keep;
                busy_l   <= 1'b1;
                out_sh_l <= load_word;
            end else if (fall_no == EDGE_DATA) begin
                busy_l <= 1'b0;
            end else if (fall_no == EDGE_END) begin
                win_l  <= 1'b0;
                conv_l <= 1'b0;
            end
            if (fall_no >= EDGE_DATA) begin
                dout_l   <= out_sh_l[RES_W-1];
                out_sh_l <= out_sh_l << 1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Link pins
    // ------------------------------------------------------------------
    // Busy and data leave high impedance as soon as select falls.
    assign serial_dout      = dout_l;
    assign serial_dout_oe_n = chip_select_n;
    assign busy             = busy_l;
    assign busy_oe_n        = chip_select_n;

    // ------------------------------------------------------------------
    // Crossing into the core domain
    // ------------------------------------------------------------------
    assign sync_in = {chip_select_n, pen_touch_n, cmd_done_l,
                      ref_done_l, past_l, win_l, conv_l};

    tcd_sync2 #(
        .W    (SYNC_W),
        .INIT (SYNC_RST)
    ) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in (sync_in),
        .sync_out (sync_q)
    );

    assign cs_s  = sync_q[6];
    assign pen_s = sync_q[5];
    assign lnk_s = tcd_link_s'(sync_q[4:0]);

    // Marker edges; the words behind them settled on the marker's own rise, two core stages earlier
    wire logic done_rise = lnk_s.cmd_done & ~done_d_r;
    wire logic ref_rise  = lnk_s.ref_done & ~ref_d_r;
    wire logic sleep_cmd = (word_l.channel_select == CH_SLEEP) &&
                           !word_l.input_config_select;
    wire logic sleep_hi  = (mode_r == TCD_SLEEP) && cs_s;
    wire logic pd_both   = cfg_r.reference_power_bit &&
                           cfg_r.converter_power_bit;

    // ------------------------------------------------------------------
    // Edge detectors and result holding
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            done_d_r   <= 1'b0;
            ref_d_r    <= 1'b0;
            adc_hold_r <= '0;
        end else begin
            done_d_r <= lnk_s.cmd_done;
            ref_d_r  <= lnk_s.ref_done;
            if (cs_s) begin
                adc_hold_r <= adc_result;
            end
        end
    end

    // ------------------------------------------------------------------
    // Held configuration, replaced by a complete command; reference bit at rise seven
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cfg_r <= tcd_cmd_s'(CMD_RST);
            ref_r <= 1'b0;
        end else begin
            if (done_rise) begin
                cfg_r <= word_l;
            end
            if (ref_rise) begin
                ref_r <= ref_l;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sleep state
    // ------------------------------------------------------------------
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            TCD_NORMAL: begin
                if (done_rise && sleep_cmd) begin
                    mode_nxt = TCD_SLEEP;
                end
            end
            TCD_SLEEP: begin
                if (done_rise && !sleep_cmd) begin
                    mode_nxt = TCD_NORMAL;
                end
            end
            default: mode_nxt = TCD_NORMAL;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            mode_r <= TCD_NORMAL;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Plate switches
    // ------------------------------------------------------------------
    // The window uses the channel of the command in flight; outside it
    // the held command keeps its plates to rise five while the converter bit says so, and past rise eight for X and Y only.
    wire logic hold_old   = cfg_r.converter_power_bit && !lnk_s.past_track;
    wire logic keep_axis  = cfg_r.converter_power_bit && lnk_s.cmd_done &&
                            is_axis(cfg_r.channel_select);
    wire tcd_plate_s yn_only = '{1'b0, 1'b0, 1'b0, 1'b1};

    always_comb begin
        if (sleep_hi) begin
            plate_nxt = '0;
        end else if (cs_s) begin
            plate_nxt = yn_only;
        end else if (lnk_s.drive_win) begin
            plate_nxt = plates_of(chan_l);
        end else if (hold_old || keep_axis) begin
            plate_nxt = plates_of(cfg_r.channel_select);
        end else begin
            plate_nxt = '0;
        end
    end

    // ------------------------------------------------------------------
    // Pen interrupt pin
    // ------------------------------------------------------------------
    // During a conversion the pin is forced to a level set by the channel
    // so for X and Y the host sees a touch it cannot trust; it should mask then.
    always_comb begin
        irq_oe_n_nxt = 1'b0;
        irq_nxt      = pen_s;
        if (sleep_hi) begin
            irq_oe_n_nxt = cfg_r.res_8bit;
            irq_nxt      = 1'b1;
        end else if (cs_s) begin
            irq_nxt = pd_both ? 1'b1 : pen_s;
        end else if (lnk_s.conv_win) begin
            irq_nxt = !is_axis(chan_l);
        end else if (cfg_r.converter_power_bit) begin
            irq_nxt = !is_axis(cfg_r.channel_select);
        end else begin
            irq_nxt = pen_s;
        end
    end

    // ------------------------------------------------------------------
    // Converter power
    // ------------------------------------------------------------------
    // Sleep keeps the power bits of its own command, since that command
    // is loaded into the held configuration like any other.
    assign adc_pwr_nxt = lnk_s.conv_win ||
                         (cfg_r.converter_power_bit &&
                          (!cs_s || cfg_r.reference_power_bit));

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            plate_r    <= '0;
            irq_r      <= 1'b1;
            irq_oe_n_r <= 1'b0;
            adc_pwr_r  <= 1'b0;
        end else begin
            plate_r    <= plate_nxt;
            irq_r      <= irq_nxt;
            irq_oe_n_r <= irq_oe_n_nxt;
            adc_pwr_r  <= adc_pwr_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Core outputs
    // ------------------------------------------------------------------
    // Channel and input mode reach the analog mux straight from the
    // held command word.
    assign active_cmd     = cfg_r;
    assign ref_power_on   = ref_r;
    assign adc_power_on   = adc_pwr_r;
    assign sleep_active   = (mode_r == TCD_SLEEP);
    assign plate_sw       = plate_r;
    assign touch_irq_n    = irq_r;
    assign touch_irq_oe_n = irq_oe_n_r;

endmodule // tcd_cmd_decoder

// ==== common/tcd_pkg.sv ====
/*
 * Shared constants, carriers and decode helpers of the touch converter
 * command decoder.
 * Assumes one serial command per chip select frame, shifted MSB first.
 */
package tcd_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          CMD_W   = 8;
    localparam int          RES_W   = 12;
    localparam int          SYNC_W  = 7;
    localparam logic [7:0]  CMD_RST = 8'h00;   // Same as all-zero init
    localparam logic [6:0]  SYNC_RST = 7'h60;  // Chip select, pen idle high

    // ------------------------------------------------------------------
    // Shift clock edge numbers, counted from the start bit as edge one
    // ------------------------------------------------------------------
    localparam logic [4:0]  EDGE_CHAN  = 5'h04;
    localparam logic [4:0]  EDGE_TRACK = 5'h05;
    localparam logic [4:0]  EDGE_REF   = 5'h07;
    localparam logic [4:0]  EDGE_CMD   = 5'h08;
    localparam logic [4:0]  EDGE_DATA  = 5'h09;
    localparam logic [4:0]  EDGE_END   = 5'h14;
    localparam logic [4:0]  EDGE_SAT   = 5'h1F;

    // ------------------------------------------------------------------
    // Channel codes
    // ------------------------------------------------------------------
    localparam logic [2:0]  CH_DIODE_LOW_CURRENT = 3'h0;
    localparam logic [2:0]  CH_Y     = 3'h1;
    localparam logic [2:0]  CH_VBAT  = 3'h2;
    localparam logic [2:0]  CH_Z1    = 3'h3;
    localparam logic [2:0]  CH_Z2    = 3'h4;
    localparam logic [2:0]  CH_X     = 3'h5;
    localparam logic [2:0]  CH_SLEEP = 3'h6;
    localparam logic [2:0]  CH_DIODE_HIGH_CURRENT = 3'h7;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       start;
        logic [2:0] channel_select;
        logic       res_8bit;
        logic       input_config_select;
        logic       reference_power_bit;
        logic       converter_power_bit;
    } tcd_cmd_s;

    typedef struct packed {
        logic x_plate_pos;
        logic x_plate_neg;
        logic y_plate_pos;
        logic y_plate_neg;
    } tcd_plate_s;

    typedef struct packed {
        logic cmd_done;
        logic ref_done;
        logic past_track;
        logic drive_win;
        logic conv_win;
    } tcd_link_s;

    typedef enum logic [1:0] {
        TCD_NORMAL = 2'b01,
        TCD_SLEEP  = 2'b10
    } tcd_mode_e;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic tcd_plate_s plates_of(input logic [2:0] ch);
        tcd_plate_s p;
        p = '0;
        case (ch)
            CH_Y:        p = '{1'b0, 1'b0, 1'b1, 1'b1};
            CH_X:        p = '{1'b1, 1'b1, 1'b0, 1'b0};
            CH_Z1, CH_Z2: p = '{1'b0, 1'b1, 1'b1, 1'b0};
            default:     p = '0;
        endcase
        return p;
    endfunction

    function automatic logic is_axis(input logic [2:0] ch);
        return (ch == CH_X) || (ch == CH_Y);
    endfunction

    function automatic logic is_na_diff(input logic [2:0] ch);
        return (ch == CH_DIODE_LOW_CURRENT) || (ch == CH_VBAT) || (ch == CH_DIODE_HIGH_CURRENT);
    endfunction

endpackage

// ==== rtl/tcd_sync2.sv ====
/*
 * Two flip-flop level synchroniser into the core clock domain.
 * Assumes each input bit is an independent level; words are not
 * safe through it.
 */
`timescale 1ns/1ps

module tcd_sync2 #(
    parameter int               W    = 1,
    parameter logic [W-1:0]     INIT = '0
) (
    input  wire logic           core_clk,
    input  wire logic           rst_b,
    input  wire logic [W-1:0]   async_in,
    output logic      [W-1:0]   sync_out
);

    logic [W-1:0] meta_r;

    // ------------------------------------------------------------------
    // Two stages; only the second stage is visible outside
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            meta_r   <= INIT;
            sync_out <= INIT;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule // tcd_sync2

// ==== dv/tcd_cmd_decoder_assertions.sv ====
/* Pin checks of the command decoder, core clock domain.
   Assumes it is bound to tcd_cmd_decoder. */
`timescale 1ns/1ps
module tcd_cmd_decoder_assertions
    import tcd_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       chip_select_n,
    input wire logic       touch_irq_n,
    input wire logic       touch_irq_oe_n,
    input wire tcd_cmd_s   active_cmd,
    input wire logic       ref_power_on,
    input wire logic       adc_power_on,
    input wire logic       sleep_active,
    input wire tcd_plate_s plate_sw
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Six idle cycles cover the two-stage select crossing and the output register
    wire slp = active_cmd[6:4] == CH_SLEEP && !active_cmd[2];
    sequence asleep; (chip_select_n && sleep_active) [*6]; endsequence
    sequence awake; (chip_select_n && !sleep_active) [*6]; endsequence
    chk_reset_awake: assert property ($rose(rst_b) |->
        !sleep_active && active_cmd == CMD_RST) else $error("bad reset");
    chk_sleep_cmd: assert property ($stable(active_cmd) &&
        $stable(sleep_active) |-> sleep_active == slp) else $error("sleep");
    chk_sleep_open: assert property (asleep |-> plate_sw == 4'h0)
        else $error("plates not open in sleep");
    chk_sleep_irq: assert property (asleep |->
        touch_irq_oe_n == active_cmd[3] && (active_cmd[3] || touch_irq_n))
        else $error("sleep irq");
    chk_idle_ground: assert property (awake |-> plate_sw == 4'h1)
        else $error("idle plates");
    chk_irq_forced: assert property (awake ##0 active_cmd[1:0] == 2'h3
        |-> touch_irq_n && !touch_irq_oe_n) else $error("irq not forced");
    chk_ref_level: assert property (chip_select_n [*8] |->
        ref_power_on == active_cmd[1]) else $error("reference power");
    chk_adc_idle: assert property (chip_select_n [*6] |->
        adc_power_on == (active_cmd[0] && active_cmd[1])) else $error("adc");
endmodule // tcd_cmd_decoder_assertions
bind tcd_cmd_decoder tcd_cmd_decoder_assertions
    tcd_cmd_decoder_assertions_inst (
    .core_clk(core_clk), .rst_b(rst_b), .chip_select_n(chip_select_n),
    .touch_irq_n(touch_irq_n), .touch_irq_oe_n(touch_irq_oe_n),
    .active_cmd(active_cmd), .ref_power_on(ref_power_on),
    .adc_power_on(adc_power_on), .sleep_active(sleep_active),
    .plate_sw(plate_sw));

// ==== dv/tcd_host_model.sv ====
/* Host end of the serial link: one frame per raised go.
   Assumes the bench holds go until done. */
`timescale 1ns/1ps
module tcd_host_model (
    input  wire logic        go,
    input  wire logic [7:0]  cmd,
    input  wire logic [4:0]  n_clk,
    input  wire logic        serial_dout,
    input  wire logic        busy,
    input  wire logic        serial_dout_oe_n,
    input  wire logic        busy_oe_n,
    output logic             shift_clock,
    output logic             chip_select_n,
    output logic             serial_din,
    output logic             done,
    output logic [11:0]      rd_data,
    output logic [3:0]       pin_trace
);
    // Idle: select high, clock parked low
    initial begin
        shift_clock = 1'b0;
        chip_select_n = 1'b1;
        serial_din = 1'b0;
        done = 1'b0;
        rd_data = 12'h000;
        pin_trace = 4'h0;
    end
    // Frame with a 32 ns clock; result taken at rises ten onward
    always @(posedge go) begin
        #3 chip_select_n = 1'b0;
        for (int i = 0; i < n_clk; i++) begin
            #13 serial_din = (i < 8) ? cmd[7 - i] : 1'b0;
            #3 if (i > 8 && i < 21) rd_data = {rd_data[10:0], serial_dout};
            // Busy and enables seen just before rises nine and ten
            if (i == 8) pin_trace[3:1] = {busy, serial_dout_oe_n, busy_oe_n};
            if (i == 9) pin_trace[0] = busy;
            shift_clock = 1'b1;
            #16 shift_clock = 1'b0;
        end
        #60 chip_select_n = 1'b1;
        serial_din = ~serial_din; // Released line keeps no old value
        #100 done = 1'b1;
    end
    always @(negedge go) done = 1'b0;
endmodule // tcd_host_model

// ==== dv/tcd_cmd_decoder_tb.sv ====
/* Bench of the command decoder: frames sent through the host model.
   Assumes the bound checker watches the idle states. */
`timescale 1ns/1ps
module tcd_cmd_decoder_tb
    import tcd_pkg::*;
;
    logic        core_clk, rst_b, go, pen_touch_n, shift_clock, done;
    logic        chip_select_n, serial_din, serial_dout, touch_irq_n;
    logic        ref_power_on, sleep_active, busy, dout_oe_n, busy_oe_n;
    logic [3:0]  pin_trace;
    logic [7:0]  cmd, c;
    logic [4:0]  n_clk;
    logic [11:0] rd_data, adc_result;
    tcd_cmd_s    active_cmd;
    tcd_plate_s  plate_sw, probe;
    int          fail_count, num_checks;
    logic [3:0]  pl [8] = '{4'h0, 4'h0, 4'h0, 4'h6, 4'h0, 4'hC, 4'h0, 4'h0};
    tcd_cmd_decoder tcd_cmd_decoder_inst (.core_clk(core_clk), .rst_b(rst_b),
        .shift_clock(shift_clock), .chip_select_n(chip_select_n),
        .serial_din(serial_din), .pen_touch_n(pen_touch_n),
        .adc_result(adc_result), .serial_dout(serial_dout),
        .serial_dout_oe_n(dout_oe_n), .busy(busy), .busy_oe_n(busy_oe_n),
        .touch_irq_n(touch_irq_n),
        .touch_irq_oe_n(), .active_cmd(active_cmd), .adc_power_on(),
        .ref_power_on(ref_power_on), .sleep_active(sleep_active),
        .plate_sw(plate_sw));
    tcd_host_model tcd_host_model_inst (.go(go), .cmd(cmd), .n_clk(n_clk),
        .serial_dout(serial_dout), .shift_clock(shift_clock), .done(done),
        .chip_select_n(chip_select_n), .serial_din(serial_din),
        .rd_data(rd_data), .busy(busy), .serial_dout_oe_n(dout_oe_n),
        .busy_oe_n(busy_oe_n), .pin_trace(pin_trace));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic check(input string w, input logic [11:0] g, e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask
    // Plates probed near rise ten, inside the differential window
    task automatic frame(input logic [7:0] x, input logic [4:0] n);
        @(posedge core_clk);
        cmd <= x;
        n_clk <= n;
        go <= 1'b1;
        repeat (40) @(posedge core_clk);
        probe = plate_sw;
        for (int k = 0; k < 400 && !done; k++) @(posedge core_clk);
        check("done", {11'h0, done}, 12'h001);
        go <= 1'b0;
        repeat (12) @(posedge core_clk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog: twelve frames need about 12 us
    initial begin
        #40000 fail_count++;
        complete_run;
    end
    initial begin
        {rst_b, go, cmd, n_clk} = '0;
        {fail_count, num_checks} = '0;
        pen_touch_n = 1'b1;
        adc_result = 12'hA5C;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        check("config", {4'h0, active_cmd}, 12'h000);
        frame(8'h00, 5'h18);
        for (int m = 0; m < 8; m++) begin
            c = {1'b1, m[2:0], m[0], ~m[1], m[1], m[2]};
            frame(c, 5'h18);
            check("plates", {8'h0, probe}, {8'h0, pl[m]});
            check("config", {4'h0, active_cmd}, {4'h0, c});
            check("sleep", {11'h0, sleep_active}, {11'h0, m == 6});
            check("ref", {11'h0, ref_power_on}, {11'h0, c[1]});
            check("data", rd_data, m[0] ? 12'hA50 : 12'hA5C);
            check("pins", {8'h0, pin_trace}, 12'h008);
            check("oe", {10'h0, dout_oe_n, busy_oe_n}, 12'h003);
        end
        frame(8'hEA, 5'h18);
        frame(8'h95, 5'h05);
        check("config", {4'h0, active_cmd}, 12'h0EA);
        frame(8'h90, 5'h18);
        check("sleep", {11'h0, sleep_active}, 12'h000);
        pen_touch_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        check("irq", {11'h0, touch_irq_n}, 12'h000);
        complete_run;
    end
endmodule // tcd_cmd_decoder_tb
